// file: src/zcd_pkg.sv
// package: register map, field positions and reset values of the zero-cross control block
// ==========================================================================
// ==========================================================================
package zcd_pkg;
    // byte addresses of the word registers
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] status_addr = 8'h04;
    localparam logic [7:0] mask_addr = 8'h08;
    // control register field positions
    localparam int en_bit = 7;
    localparam int lvl_bit = 5;
    localparam int inv_bit = 4;
    localparam int rise_bit = 1;
    localparam int fall_bit = 0;
    // writable bits of the control register
    localparam logic [7:0] ctrl_wmask = 8'h93;
    // status layout: bit 0 is the edge flag
    localparam int flag_bit = 0;
    localparam logic [31:0] status_wmask = 32'h0000_0001;
    // ahb transfer codes
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [2:0] hsize_word = 3'h2;
    // reset values
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [31:0] mask_reset = 32'h0000_0000;
    // bus slave states
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_data = 2'b10
    } bus_state_t;
endpackage : zcd_pkg

// file: src/zcd_edge.sv
// module: sampler and edge detector for the detector logic output
`timescale 1ns/1ps
module zcd_edge
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic level_in,
    output logic level_q,
    output logic rise_pulse,
    output logic fall_pulse
);
    // ==========================================================================
    // edge detection
    // ==========================================================================
    logic level_d;
    // next sample is just the input, which is taken as synchronous
    always_comb
    begin
        level_d = level_in;
    end
    // register the level, reset low
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            level_q <= 1'b0;
        end
        else
        begin
            level_q <= level_d;
        end
    end
    // combinational edge strobes against the held sample
    assign rise_pulse = level_d & ~level_q;
    assign fall_pulse = ~level_d & level_q;
endmodule : zcd_edge

// file: src/zcd_ctrl.sv
// module: zero-cross detector control, status and ahb-lite register slave
`timescale 1ns/1ps
module zcd_ctrl
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic comp_sinking,
    input wire logic fuse_off,
    input wire logic sleep_mode,
    output logic det_active,
    output logic zero_cross_out_pin,
    output logic irq
);
    // ==========================================================================
    // state
    // ==========================================================================
    // software control, interrupt and bus slave registers
    logic [7:0] ctrl_q; // software control bits
    logic [7:0] ctrl_d;
    logic flag_q; // sticky edge flag
    logic flag_d;
    logic [31:0] mask_q; // interrupt mask, same layout as status
    logic [31:0] mask_d;
    zcd_pkg::bus_state_t state_q; // bus slave phase
    zcd_pkg::bus_state_t state_d;
    logic [7:0] addr_q; // latched address phase
    logic [7:0] addr_d;
    logic wr_q; // latched write flag
    logic wr_d;
    logic [31:0] rdata_q; // registered read data
    logic [31:0] rdata_d;
    logic pin_q; // observation pin
    logic pin_d;
    logic irq_q;
    logic irq_d;
    logic boot_q; // first cycle after reset release
    logic boot_d; // boot marker next value
    // combinational helpers
    logic logic_out; // detector logic output after inversion
    logic edge_level;
    logic rise_pulse;
    logic fall_pulse;
    logic take; // address phase accepted
    logic set_flag;
    logic status_read;
    // bits a control read may show: writable ones plus the live level
    localparam logic [7:0] ctrl_rbits = zcd_pkg::ctrl_wmask | 8'(1 << zcd_pkg::lvl_bit);
    localparam logic [31:0] ctrl_rmask = {24'h00_0000, ctrl_rbits};
    // ==========================================================================
    // detector logic output
    // ==========================================================================
    // inversion applies before edges and the level bit
    assign logic_out = comp_sinking ^ ctrl_q[zcd_pkg::inv_bit];
    // sleep_mode is deliberately unused by the edge path: the flag keeps working
    // the sampler lags one cycle, so each edge is a single-cycle strobe
    zcd_edge u_edge
    (
        .core_clk(core_clk),
        .rst(rst),
        .level_in(logic_out),
        .level_q(edge_level),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse)
    );
    // edge qualification by the two enable bits, independent of sleep
    assign set_flag = (rise_pulse & ctrl_q[zcd_pkg::rise_bit])
        | (fall_pulse & ctrl_q[zcd_pkg::fall_bit]);
    // ==========================================================================
    // bus decode
    // ==========================================================================
    // accepted only when the bus is ready and the transfer is real
    assign take = hsel & hready & (htrans == zcd_pkg::htrans_nonseq);
    // a status read clears the flag at its address phase
    assign status_read = take & ~hwrite & (haddr == zcd_pkg::status_addr);
    // ==========================================================================
    // next state
    // ==========================================================================
    // one-cycle-wait-free slave: address phase latched, data phase acts
    always_comb
    begin
        // every next value but pin_d and irq_d starts from its register so nothing latches
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        flag_d = flag_q;
        addr_d = addr_q;
        wr_d = wr_q;
        rdata_d = rdata_q;
        state_d = state_q;
        // fuse strap sampled once after release
        if (boot_q)
        begin
            ctrl_d[zcd_pkg::en_bit] = ~fuse_off;
        end
        // writes happen in the data phase
        if (state_q == zcd_pkg::st_data && wr_q)
        begin
            case (addr_q)
                zcd_pkg::ctrl_addr:
                begin
                    ctrl_d = hwdata[7:0] & zcd_pkg::ctrl_wmask;
                end
                zcd_pkg::mask_addr:
                begin
                    mask_d = hwdata & zcd_pkg::status_wmask;
                end
                // status writes fall through here and are dropped
                default:
                begin
                    ctrl_d = ctrl_d; // unmapped or read-only: ignored
                end
            endcase
        end
        // read of status clears, but a new edge wins
        if (status_read)
        begin
            flag_d = 1'b0;
        end
        if (set_flag)
        begin
            flag_d = 1'b1;
        end
        // address phase capture and read data
        case (state_q)
            zcd_pkg::st_idle,
            zcd_pkg::st_data:
            begin
                if (take)
                begin
                    state_d = zcd_pkg::st_data;
                    addr_d = haddr;
                    wr_d = hwrite;
                    rdata_d = 32'h0000_0000;
                    // read data is captured in the address phase, shown in the data phase
                    if (!hwrite)
                    begin
                        case (haddr)
                            zcd_pkg::ctrl_addr:
                            begin
                                rdata_d[7:0] = ctrl_q & zcd_pkg::ctrl_wmask;
                                rdata_d[zcd_pkg::lvl_bit] = logic_out;
                            end
                            zcd_pkg::status_addr:
                            begin
                                rdata_d[zcd_pkg::flag_bit] = flag_q;
                            end
                            zcd_pkg::mask_addr:
                            begin
                                rdata_d = mask_q;
                            end
                            default:
                            begin
                                rdata_d = 32'h0000_0000;
                            end
                        endcase
                    end
                end
                // no transfer: drop back to idle
                else
                begin
                    state_d = zcd_pkg::st_idle;
                    wr_d = 1'b0;
                end
            end
            // illegal state code: recover to idle
            default:
            begin
                state_d = zcd_pkg::st_idle;
            end
        endcase
        // outputs
        // pin follows the next enable so a write shows one cycle sooner
        pin_d = ctrl_d[zcd_pkg::en_bit] & logic_out;
        irq_d = flag_d & mask_d[zcd_pkg::flag_bit];
    end
    // boot marker: high through reset and in the cycle right after reset release, low after that
    always_comb
    begin
        boot_d = 1'b0;
    end
    // ==========================================================================
    // registers
    // ==========================================================================
    // plain registers, synchronous reset
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            // boot marker starts high so the fuse strap loads once
            ctrl_q <= zcd_pkg::ctrl_reset;
            mask_q <= zcd_pkg::mask_reset;
            flag_q <= 1'b0;
            state_q <= zcd_pkg::st_idle;
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            pin_q <= 1'b0;
            irq_q <= 1'b0;
            boot_q <= 1'b1;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            flag_q <= flag_d;
            state_q <= state_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
            rdata_q <= rdata_d;
            pin_q <= pin_d;
            irq_q <= irq_d;
            boot_q <= boot_d;
        end
    end
    // bus outputs: the answer never waits, the response is always okay
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // pin and interrupt come straight from their registers
    assign zero_cross_out_pin = pin_q;
    assign irq = irq_q;
    assign det_active = ctrl_q[zcd_pkg::en_bit];
    // ==========================================================================
    // checks
    // ==========================================================================
    // only writable bits may ever be held in the control register
    chk_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        (ctrl_q & ~zcd_pkg::ctrl_wmask) == 8'h00)
        else $error("reserved control bits not zero");
    // a control read shows nothing outside the defined fields
    chk_reserved_read: assert property (@(posedge core_clk) disable iff (rst)
        !rst && take && !hwrite && haddr == zcd_pkg::ctrl_addr
        |=> (hrdata & ~ctrl_rmask) == 32'h0000_0000)
        else $error("reserved control bits read non-zero");
    // a control write lands, masked to the writable bits, at the end of its data phase
    chk_write_ctrl: assert property (@(posedge core_clk) disable iff (rst)
        !rst && state_q == zcd_pkg::st_data && wr_q && addr_q == zcd_pkg::ctrl_addr
        |=> ctrl_q == ($past(hwdata[7:0]) & zcd_pkg::ctrl_wmask))
        else $error("control write lost");
    // control holds unless written or loaded from the fuse
    chk_ctrl_hold: assert property (@(posedge core_clk) disable iff (rst)
        !rst && !boot_q
        && !(state_q == zcd_pkg::st_data && wr_q && addr_q == zcd_pkg::ctrl_addr)
        |=> $stable(ctrl_q))
        else $error("control changed without a write");
    // the level bit is the live logic output after inversion
    chk_level_read: assert property (@(posedge core_clk) disable iff (rst)
        !rst && take && !hwrite && haddr == zcd_pkg::ctrl_addr
        |=> hrdata[zcd_pkg::lvl_bit] == $past(logic_out))
        else $error("level bit mismatch");
    // enabled edges set the flag one cycle later
    chk_rise_sets: assert property (@(posedge core_clk) disable iff (rst)
        rise_pulse && ctrl_q[zcd_pkg::rise_bit] |=> flag_q)
        else $error("enabled rising edge did not set flag");
    chk_fall_sets: assert property (@(posedge core_clk) disable iff (rst)
        fall_pulse && ctrl_q[zcd_pkg::fall_bit] |=> flag_q)
        else $error("enabled falling edge did not set flag");
    // a rising edge with its enable clear leaves a clear flag clear
    chk_rise_masked: assert property (@(posedge core_clk) disable iff (rst)
        !rst && !flag_q && rise_pulse && !ctrl_q[zcd_pkg::rise_bit] |=> !flag_q)
        else $error("disabled rising edge set flag");
    // a falling edge with its enable clear leaves a clear flag clear
    chk_fall_masked: assert property (@(posedge core_clk) disable iff (rst)
        !rst && !flag_q && fall_pulse && !ctrl_q[zcd_pkg::fall_bit] |=> !flag_q)
        else $error("disabled falling edge set flag");
    // the flag only drops through a status read
    chk_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
        flag_q && !status_read |=> flag_q)
        else $error("flag dropped without status read");
    // a status read clears the flag unless an edge lands with it
    chk_status_clear: assert property (@(posedge core_clk) disable iff (rst)
        !rst && status_read && !set_flag |=> !flag_q)
        else $error("status read did not clear flag");
    // a newly set flag always has an enabled edge behind it
    chk_flag_cause: assert property (@(posedge core_clk) disable iff (rst)
        !flag_q ##1 flag_q |-> $past(set_flag))
        else $error("flag set without enabled edge");
    // the interrupt line is the flag gated by its mask bit
    chk_irq_level: assert property (@(posedge core_clk) disable iff (rst)
        irq == (flag_q & mask_q[zcd_pkg::flag_bit]))
        else $error("interrupt line mismatch");
    // the pin shows the logic output one cycle later while enabled
    chk_pin_route: assert property (@(posedge core_clk) disable iff (rst)
        !rst |=> zero_cross_out_pin == ($past(ctrl_d[zcd_pkg::en_bit]) & $past(logic_out)))
        else $error("observation pin mismatch");
    // with the enable clear the observation pin stays low
    chk_pin_off: assert property (@(posedge core_clk) disable iff (rst)
        !rst && !ctrl_d[zcd_pkg::en_bit] |=> !zero_cross_out_pin)
        else $error("pin driven while disabled");
    // the sampler sees the comparator through the invert bit
    chk_invert_path: assert property (@(posedge core_clk) disable iff (rst)
        !rst |=> edge_level == ($past(comp_sinking) ^ $past(ctrl_q[zcd_pkg::inv_bit])))
        else $error("inversion wrong");
    // read data stands until the next accepted transfer
    chk_read_hold: assert property (@(posedge core_clk) disable iff (rst)
        !rst && !take |=> $stable(hrdata))
        else $error("read data changed without a transfer");
    // sleep does not gate the edge path
    chk_sleep_edge: assert property (@(posedge core_clk) disable iff (rst)
        sleep_mode && rise_pulse && ctrl_q[zcd_pkg::rise_bit] |=> flag_q)
        else $error("edge lost in sleep");
    // the marker is high through reset too, so only its post-release cycle counts
    chk_fuse_boot: assert property (@(posedge core_clk) disable iff (rst)
        !rst && boot_q
        |=> (det_active == !$past(fuse_off)) || $past(state_q == zcd_pkg::st_data))
        else $error("fuse default not applied");
endmodule : zcd_ctrl

// file: verif/zcd_wave.sv
// partner model: comparator view of an ac waveform through a series resistor
`timescale 1ns/1ps
module zcd_wave
#(
    parameter int half_cyc = 5 // cycles per half wave
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    output logic comp_sinking
);
    logic [7:0] cnt_q; // half wave timer
    // ======================================================
    // wave: the pin level only moves while the wave runs,
    // so the bench controls how many crossings happen
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_q <= 8'h00;
            comp_sinking <= 1'b0;
        end
        else if (run)
        begin
            cnt_q <= (cnt_q == 8'(half_cyc - 1)) ? 8'h00 : cnt_q + 8'h01;
            if (cnt_q == 8'(half_cyc - 1))
            begin
                comp_sinking <= ~comp_sinking; // one zero crossing
            end
        end
    end
endmodule : zcd_wave

// file: verif/tb_top.sv
// testbench: fuse, register fields, level, pin and edge flag scenarios
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = zcd_pkg::hsize_word; // word transfers only
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, det_active, out_pin, irq, comp_sinking;
    logic fuse_off = 1'b0;
    logic sleep_mode = 1'b0;
    logic run = 1'b0;
    logic sink_exp = 1'b0; // comparator level the bench expects
    logic [31:0] rd; // last read data
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;

    always #4 core_clk = ~core_clk;

    zcd_ctrl DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .comp_sinking(comp_sinking), .fuse_off(fuse_off), .sleep_mode(sleep_mode),
        .det_active(det_active), .zero_cross_out_pin(out_pin), .irq(irq));
    zcd_wave wave (.core_clk(core_clk), .rst(rst), .run(run), .comp_sinking(comp_sinking));

    // ======================================================
    // helpers
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // single ahb transfer; holds each phase until hready is seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= zcd_pkg::htrans_nonseq;
        haddr <= a;
        hwrite <= wr;
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
            @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
            @(posedge core_clk);
        rd = hrdata;
    endtask : bus

    // reset held two cycles; enable loads from the fuse after release
    task automatic do_reset(input logic fuse);
        rst <= 1'b1;
        fuse_off <= fuse;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        sink_exp = 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : do_reset

    // let the wave make exactly one crossing, then settle
    task automatic one_edge;
        run <= 1'b1;
        @(posedge core_clk);
        while (comp_sinking === sink_exp)
            @(posedge core_clk);
        run <= 1'b0;
        sink_exp = ~sink_exp;
        repeat (4) @(posedge core_clk);
    endtask : one_edge

    // ======================================================
    // scenarios
    task automatic t_fuse;
        do_reset(1'b0);
        check("active", {31'h0, det_active}, 32'h1);
        bus(1'b0, zcd_pkg::ctrl_addr, 32'h0);
        check("ctrl", rd, 32'h80);
        bus(1'b0, zcd_pkg::mask_addr, 32'h0);
        check("mask", rd, zcd_pkg::mask_reset);
        do_reset(1'b1);
        check("inactive", {31'h0, det_active}, 32'h0);
        bus(1'b1, zcd_pkg::ctrl_addr, 32'h80);
        bus(1'b0, zcd_pkg::ctrl_addr, 32'h0);
        check("enabled", {31'h0, det_active}, 32'h1);
    endtask : t_fuse

    task automatic t_fields;
        bus(1'b1, zcd_pkg::ctrl_addr, 32'hff);
        bus(1'b0, zcd_pkg::ctrl_addr, 32'h0);
        check("ctrl_ff", rd, 32'hb3);
        bus(1'b1, 8'h0c, 32'hff);
        bus(1'b0, 8'h0c, 32'h0);
        check("unmapped", rd, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        check("hready", {31'h0, hreadyout}, 32'h1);
        // turning the invert on with rise enabled made a rising logic edge
        bus(1'b1, zcd_pkg::status_addr, 32'h0);
        bus(1'b0, zcd_pkg::status_addr, 32'h0);
        check("invert_edge", rd, 32'h1);
    endtask : t_fields

    task automatic t_level;
        for (int i = 0; i < 4; i++)
        begin
            if (i == 2)
                one_edge();
            bus(1'b1, zcd_pkg::ctrl_addr, {24'h0, 1'b1, 2'b00, i[0], 4'h0});
            bus(1'b0, zcd_pkg::ctrl_addr, 32'h0);
            check("level", rd, {24'h0, 2'b10, sink_exp ^ i[0], i[0], 4'h0});
            check("pin", {31'h0, out_pin}, {31'h0, sink_exp ^ i[0]});
        end
        bus(1'b1, zcd_pkg::ctrl_addr, 32'h0);
        bus(1'b0, zcd_pkg::ctrl_addr, 32'h0);
        check("pin_off", {31'h0, out_pin}, 32'h0);
    endtask : t_level

    // every rise/fall enable combination, sleep on in half of them
    task automatic t_edges;
        bus(1'b1, zcd_pkg::mask_addr, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            sleep_mode <= m[1];
            bus(1'b1, zcd_pkg::ctrl_addr, {24'h0, 6'h20, m[1:0]});
            if (sink_exp)
                one_edge();
            bus(1'b0, zcd_pkg::status_addr, 32'h0);
            one_edge();
            check("irq", {31'h0, irq}, {31'h0, m[1]});
            bus(1'b0, zcd_pkg::status_addr, 32'h0);
            check("rise", rd, {31'h0, m[1]});
            one_edge();
            bus(1'b0, zcd_pkg::status_addr, 32'h0);
            check("fall", rd, {31'h0, m[0]});
        end
    endtask : t_edges

    task automatic t_sticky;
        sleep_mode <= 1'b0;
        bus(1'b1, zcd_pkg::ctrl_addr, 32'h83);
        bus(1'b0, zcd_pkg::status_addr, 32'h0);
        one_edge();
        one_edge();
        bus(1'b0, zcd_pkg::status_addr, 32'h0);
        check("sticky", rd, 32'h1);
        bus(1'b0, zcd_pkg::status_addr, 32'h0);
        check("cleared", rd, 32'h0);
        check("irq_low", {31'h0, irq}, 32'h0);
        bus(1'b1, zcd_pkg::mask_addr, 32'h0);
        one_edge();
        check("masked", {31'h0, irq}, 32'h0);
        bus(1'b0, zcd_pkg::status_addr, 32'h0);
        check("flag_masked", rd, 32'h1);
    endtask : t_sticky

    // ======================================================
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    initial
    begin
        t_fuse();
        t_fields();
        t_level();
        t_edges();
        t_sticky();
        give_verdict();
    end
endmodule : tb_top
